// ===== rtl/irq_ctrl_pkg.sv
// Functional notes
// - Two priority levels; every source except the watchdog (fixed high) can be put on high or low.
// - Bit 7 of main enable gates all sources; cleared means none serviced.
// - Main enable bits 6..0: converter, timer2, UART, timer1, ext1, timer0, ext0.
// - Main level bits 6..0 pick high (1) or low (0); bit 7 reserved.
// - Extra register bits 6,5,4: interval counter, supply monitor, SPI/I2C levels.
// - Extra register bits 2,1,0 enable interval counter, supply monitor, SPI/I2C.
// - Main enable sits at A8H, resets to 00H and is bit addressable.
// - Extra register resets to A0H, whole-byte access only.
// - An enabled high request preempts a running low service routine.
// - Same-cycle requests of both levels: high one is serviced first.
// - No preemption by a request of the same level; it waits for return.
// - Equal-level ties follow the fixed polling order, supply monitor first.
// - On acceptance the core pushes the PC and loads the source's vector.
package irq_ctrl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8;
  localparam logic [7:0] ADDR_LEVEL_EXTRA = 8'hA9;
  localparam logic [7:0] ADDR_LEVEL_MAIN = 8'hB8;

  localparam logic [7:0] ENABLE_MAIN_RESET = 8'h00;
  localparam logic [7:0] LEVEL_MAIN_RESET = 8'h00;
  localparam logic [7:0] LEVEL_EXTRA_RESET = 8'hA0;

  localparam logic [7:0] LEVEL_MAIN_RESERVED_MASK = 8'h80;
  localparam logic [7:0] LEVEL_EXTRA_RESERVED_MASK = 8'h80;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GLOBAL_EN_BIT = 7;
  localparam int ADC_BIT = 6;
  localparam int TIMER2_BIT = 5;
  localparam int UART_BIT = 4;
  localparam int TIMER1_BIT = 3;
  localparam int EXT1_BIT = 2;
  localparam int TIMER0_BIT = 1;
  localparam int EXT0_BIT = 0;

  localparam int TIC_LEVEL_BIT = 6;
  localparam int PSM_LEVEL_BIT = 5;
  localparam int SPI_LEVEL_BIT = 4;
  localparam int TIC_EN_BIT = 2;
  localparam int PSM_EN_BIT = 1;
  localparam int SPI_EN_BIT = 0;

  // ****************************************
  // Polling slots, highest priority first
  // ****************************************
  localparam int NUM_SLOTS = 11;
  typedef logic [3:0] slot_t;

  localparam slot_t SLOT_PSM = 4'h0;
  localparam slot_t SLOT_WDS = 4'h1;
  localparam slot_t SLOT_EXT0 = 4'h2;
  localparam slot_t SLOT_ADC = 4'h3;
  localparam slot_t SLOT_TIMER0 = 4'h4;
  localparam slot_t SLOT_EXT1 = 4'h5;
  localparam slot_t SLOT_TIMER1 = 4'h6;
  localparam slot_t SLOT_SPI = 4'h7;
  localparam slot_t SLOT_UART = 4'h8;
  localparam slot_t SLOT_TIMER2 = 4'h9;
  localparam slot_t SLOT_TIC = 4'hA;

  // Watchdog has no enable or level bit of its own.
  localparam logic WATCHDOG_LEVEL = 1'b1;

  // ****************************************
  // Vectors
  // ****************************************
  localparam logic [15:0] VECTOR_EXT0 = 16'h0003;
  localparam logic [15:0] VECTOR_TIMER0 = 16'h000B;
  localparam logic [15:0] VECTOR_EXT1 = 16'h0013;
  localparam logic [15:0] VECTOR_TIMER1 = 16'h001B;
  localparam logic [15:0] VECTOR_UART = 16'h0023;
  localparam logic [15:0] VECTOR_TIMER2 = 16'h002B;
  localparam logic [15:0] VECTOR_ADC = 16'h0033;
  localparam logic [15:0] VECTOR_SPI = 16'h003B;
  localparam logic [15:0] VECTOR_PSM = 16'h0043;
  localparam logic [15:0] VECTOR_TIC = 16'h0053;
  localparam logic [15:0] VECTOR_WDS = 16'h005B;
  localparam logic [15:0] VECTOR_NONE = 16'h0000;

  function automatic logic [15:0] vector_of(input slot_t slot);
    logic [15:0] v;
    v = VECTOR_NONE;
    unique case (slot)
      SLOT_PSM: v = VECTOR_PSM;
      SLOT_WDS: v = VECTOR_WDS;
      SLOT_EXT0: v = VECTOR_EXT0;
      SLOT_ADC: v = VECTOR_ADC;
      SLOT_TIMER0: v = VECTOR_TIMER0;
      SLOT_EXT1: v = VECTOR_EXT1;
      SLOT_TIMER1: v = VECTOR_TIMER1;
      SLOT_SPI: v = VECTOR_SPI;
      SLOT_UART: v = VECTOR_UART;
      SLOT_TIMER2: v = VECTOR_TIMER2;
      SLOT_TIC: v = VECTOR_TIC;
      default: v = VECTOR_NONE;
    endcase
    return v;
  endfunction

endpackage

// ===== rtl/irq_priority_pick.sv
module irq_priority_pick (
  input logic [10:0] pending_i,
  output logic found_o,
  output irq_ctrl_pkg::slot_t slot_o
);

  // ****************************************
  // Fixed polling order
  // ****************************************
  // The scan runs from the lowest priority up so the lowest index wins.
  always_comb begin
    found_o = 1'b0;
    slot_o = irq_ctrl_pkg::SLOT_PSM;
    for (int i = irq_ctrl_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (pending_i[i]) begin
        found_o = 1'b1;
        slot_o = irq_ctrl_pkg::slot_t'(i);
      end
    end
  end

endmodule

// ===== rtl/irq_in_service.sv
module irq_in_service (
  input logic clk_i,
  input logic rst_i,
  input logic ack_i,
  input logic ack_high_i,
  input logic return_i,
  output logic in_service_high_o,
  output logic in_service_low_o
);

  // ****************************************
  // Active service levels
  // ****************************************
  // A return closes the innermost routine, which is the high one when both
  // are open; an acceptance in the same cycle is applied after it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_service_high_o <= 1'b0;
      in_service_low_o <= 1'b0;
    end else begin
      if (return_i) begin
        if (in_service_high_o) begin
          in_service_high_o <= 1'b0;
        end else begin
          in_service_low_o <= 1'b0;
        end
      end
      if (ack_i) begin
        if (ack_high_i) begin
          in_service_high_o <= 1'b1;
        end else begin
          in_service_low_o <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== rtl/two_level_interrupt_controller.sv
module two_level_interrupt_controller (
  input logic CORE_CLK_I,
  input logic RST_I,
  input logic [7:0] SFR_ADDR_I,
  input logic [7:0] SFR_WDATA_I,
  input logic SFR_WR_I,
  input logic SFR_RD_I,
  input logic [7:0] BIT_ADDR_I,
  input logic BIT_VALUE_I,
  input logic BIT_WR_I,
  input logic SUPPLY_MONITOR_IRQ_I,
  input logic WATCHDOG_IRQ_I,
  input logic EXT0_REQUEST_I,
  input logic ADC_DONE_IRQ_I,
  input logic TIMER0_OVERFLOW_I,
  input logic EXT1_REQUEST_I,
  input logic TIMER1_OVERFLOW_I,
  input logic I2C_IRQ_I,
  input logic SPI_IRQ_I,
  input logic UART_RX_FLAG_I,
  input logic UART_TX_FLAG_I,
  input logic TIMER2_OVERFLOW_I,
  input logic TIMER2_EXTERNAL_FLAG_I,
  input logic INTERVAL_COUNTER_IRQ_I,
  input logic IRQ_ACK_I,
  input logic IRQ_RETURN_I,
  output logic [7:0] SFR_RDATA_O,
  output logic SFR_RDATA_VALID_O,
  output logic IRQ_REQ_O,
  output logic [15:0] IRQ_VECTOR_O,
  output logic [3:0] IRQ_SOURCE_O,
  output logic IRQ_HIGH_O,
  output logic IN_SERVICE_HIGH_O,
  output logic IN_SERVICE_LOW_O
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] interrupt_enable_main;
  logic [7:0] interrupt_level_main;
  logic [7:0] interrupt_enable_level_extra;

  logic bit_hit_enable_main;
  logic bit_hit_level_main;
  logic [2:0] bit_index;

  function automatic logic [7:0] set_bit(input logic [7:0] value, input logic [2:0] index,
                                         input logic bit_value);
    logic [7:0] result;
    result = value;
    result[index] = bit_value;
    return result;
  endfunction

  // Bit addresses of a bit-addressable register share its upper five bits.
  assign bit_hit_enable_main = BIT_ADDR_I[7:3] == irq_ctrl_pkg::ADDR_ENABLE_MAIN[7:3];
  assign bit_hit_level_main = BIT_ADDR_I[7:3] == irq_ctrl_pkg::ADDR_LEVEL_MAIN[7:3];
  assign bit_index = BIT_ADDR_I[2:0];

  // A byte write to the same register in the same cycle wins over a bit write.
  // main enable at A8H
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      interrupt_enable_main <= irq_ctrl_pkg::ENABLE_MAIN_RESET;
    end else if (SFR_WR_I && SFR_ADDR_I == irq_ctrl_pkg::ADDR_ENABLE_MAIN) begin
      interrupt_enable_main <= SFR_WDATA_I;
    end else if (BIT_WR_I && bit_hit_enable_main) begin
      interrupt_enable_main <= set_bit(interrupt_enable_main, bit_index, BIT_VALUE_I);
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      interrupt_level_main <= irq_ctrl_pkg::LEVEL_MAIN_RESET;
    end else if (SFR_WR_I && SFR_ADDR_I == irq_ctrl_pkg::ADDR_LEVEL_MAIN) begin
      interrupt_level_main <= SFR_WDATA_I & ~irq_ctrl_pkg::LEVEL_MAIN_RESERVED_MASK;
    end else if (BIT_WR_I && bit_hit_level_main) begin
      interrupt_level_main <= set_bit(interrupt_level_main, bit_index, BIT_VALUE_I)
                              & ~irq_ctrl_pkg::LEVEL_MAIN_RESERVED_MASK;
    end
  end

  // The reserved top bit keeps its reset value; bit 3 is stored but unused.
  // byte-only extra register
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      interrupt_enable_level_extra <= irq_ctrl_pkg::LEVEL_EXTRA_RESET;
    end else if (SFR_WR_I && SFR_ADDR_I == irq_ctrl_pkg::ADDR_LEVEL_EXTRA) begin
      interrupt_enable_level_extra <= (SFR_WDATA_I & ~irq_ctrl_pkg::LEVEL_EXTRA_RESERVED_MASK)
                                      | (irq_ctrl_pkg::LEVEL_EXTRA_RESET
                                         & irq_ctrl_pkg::LEVEL_EXTRA_RESERVED_MASK);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] next_rdata;
  logic next_rdata_valid;

  always_comb begin
    next_rdata = 8'h00;
    next_rdata_valid = 1'b0;
    if (SFR_RD_I) begin
      unique case (SFR_ADDR_I)
        irq_ctrl_pkg::ADDR_ENABLE_MAIN: begin
          next_rdata = interrupt_enable_main;
          next_rdata_valid = 1'b1;
        end
        irq_ctrl_pkg::ADDR_LEVEL_MAIN: begin
          next_rdata = interrupt_level_main;
          next_rdata_valid = 1'b1;
        end
        irq_ctrl_pkg::ADDR_LEVEL_EXTRA: begin
          next_rdata = interrupt_enable_level_extra;
          next_rdata_valid = 1'b1;
        end
        default: begin
          next_rdata = 8'h00;
          next_rdata_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SFR_RDATA_O <= 8'h00;
      SFR_RDATA_VALID_O <= 1'b0;
    end else begin
      SFR_RDATA_O <= next_rdata;
      SFR_RDATA_VALID_O <= next_rdata_valid;
    end
  end

  // ****************************************
  // Source gathering
  // ****************************************
  logic [10:0] raw_flag;
  logic [10:0] source_enable;
  logic [10:0] source_level;
  logic global_irq_enable;

  assign global_irq_enable = interrupt_enable_main[irq_ctrl_pkg::GLOBAL_EN_BIT];

  always_comb begin
    raw_flag[irq_ctrl_pkg::SLOT_PSM] = SUPPLY_MONITOR_IRQ_I;
    raw_flag[irq_ctrl_pkg::SLOT_WDS] = WATCHDOG_IRQ_I;
    raw_flag[irq_ctrl_pkg::SLOT_EXT0] = EXT0_REQUEST_I;
    raw_flag[irq_ctrl_pkg::SLOT_ADC] = ADC_DONE_IRQ_I;
    raw_flag[irq_ctrl_pkg::SLOT_TIMER0] = TIMER0_OVERFLOW_I;
    raw_flag[irq_ctrl_pkg::SLOT_EXT1] = EXT1_REQUEST_I;
    raw_flag[irq_ctrl_pkg::SLOT_TIMER1] = TIMER1_OVERFLOW_I;
    raw_flag[irq_ctrl_pkg::SLOT_SPI] = I2C_IRQ_I | SPI_IRQ_I;
    raw_flag[irq_ctrl_pkg::SLOT_UART] = UART_RX_FLAG_I | UART_TX_FLAG_I;
    raw_flag[irq_ctrl_pkg::SLOT_TIMER2] = TIMER2_OVERFLOW_I | TIMER2_EXTERNAL_FLAG_I;
    raw_flag[irq_ctrl_pkg::SLOT_TIC] = INTERVAL_COUNTER_IRQ_I;
  end

  always_comb begin
    source_enable[irq_ctrl_pkg::SLOT_EXT0] = interrupt_enable_main[irq_ctrl_pkg::EXT0_BIT];
    source_enable[irq_ctrl_pkg::SLOT_TIMER0] = interrupt_enable_main[irq_ctrl_pkg::TIMER0_BIT];
    source_enable[irq_ctrl_pkg::SLOT_EXT1] = interrupt_enable_main[irq_ctrl_pkg::EXT1_BIT];
    source_enable[irq_ctrl_pkg::SLOT_TIMER1] = interrupt_enable_main[irq_ctrl_pkg::TIMER1_BIT];
    source_enable[irq_ctrl_pkg::SLOT_UART] = interrupt_enable_main[irq_ctrl_pkg::UART_BIT];
    source_enable[irq_ctrl_pkg::SLOT_TIMER2] = interrupt_enable_main[irq_ctrl_pkg::TIMER2_BIT];
    source_enable[irq_ctrl_pkg::SLOT_ADC] = interrupt_enable_main[irq_ctrl_pkg::ADC_BIT];
    source_enable[irq_ctrl_pkg::SLOT_TIC] = interrupt_enable_level_extra[irq_ctrl_pkg::TIC_EN_BIT];
    source_enable[irq_ctrl_pkg::SLOT_PSM] = interrupt_enable_level_extra[irq_ctrl_pkg::PSM_EN_BIT];
    source_enable[irq_ctrl_pkg::SLOT_SPI] = interrupt_enable_level_extra[irq_ctrl_pkg::SPI_EN_BIT];
    source_enable[irq_ctrl_pkg::SLOT_WDS] = 1'b1;
  end

  always_comb begin
    source_level[irq_ctrl_pkg::SLOT_EXT0] = interrupt_level_main[irq_ctrl_pkg::EXT0_BIT];
    source_level[irq_ctrl_pkg::SLOT_TIMER0] = interrupt_level_main[irq_ctrl_pkg::TIMER0_BIT];
    source_level[irq_ctrl_pkg::SLOT_EXT1] = interrupt_level_main[irq_ctrl_pkg::EXT1_BIT];
    source_level[irq_ctrl_pkg::SLOT_TIMER1] = interrupt_level_main[irq_ctrl_pkg::TIMER1_BIT];
    source_level[irq_ctrl_pkg::SLOT_UART] = interrupt_level_main[irq_ctrl_pkg::UART_BIT];
    source_level[irq_ctrl_pkg::SLOT_TIMER2] = interrupt_level_main[irq_ctrl_pkg::TIMER2_BIT];
    source_level[irq_ctrl_pkg::SLOT_ADC] = interrupt_level_main[irq_ctrl_pkg::ADC_BIT];
    source_level[irq_ctrl_pkg::SLOT_TIC] = interrupt_enable_level_extra[irq_ctrl_pkg::TIC_LEVEL_BIT];
    source_level[irq_ctrl_pkg::SLOT_PSM] = interrupt_enable_level_extra[irq_ctrl_pkg::PSM_LEVEL_BIT];
    source_level[irq_ctrl_pkg::SLOT_SPI] = interrupt_enable_level_extra[irq_ctrl_pkg::SPI_LEVEL_BIT];
    source_level[irq_ctrl_pkg::SLOT_WDS] = irq_ctrl_pkg::WATCHDOG_LEVEL;
  end

  // ****************************************
  // Masking and level split
  // ****************************************
  logic [10:0] pending;
  logic [10:0] pending_high;
  logic [10:0] pending_low;

  assign pending = raw_flag & source_enable & {irq_ctrl_pkg::NUM_SLOTS{global_irq_enable}};
  assign pending_high = pending & source_level;
  assign pending_low = pending & ~source_level;

  logic high_found;
  logic low_found;
  irq_ctrl_pkg::slot_t high_slot;
  irq_ctrl_pkg::slot_t low_slot;

  irq_priority_pick pick_high (
    .pending_i(pending_high),
    .found_o(high_found),
    .slot_o(high_slot)
  );

  irq_priority_pick pick_low (
    .pending_i(pending_low),
    .found_o(low_found),
    .slot_o(low_slot)
  );

  // ****************************************
  // Service tracking
  // ****************************************
  irq_in_service service (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .ack_i(IRQ_ACK_I & IRQ_REQ_O),
    .ack_high_i(IRQ_HIGH_O),
    .return_i(IRQ_RETURN_I),
    .in_service_high_o(IN_SERVICE_HIGH_O),
    .in_service_low_o(IN_SERVICE_LOW_O)
  );

  // ****************************************
  // Arbitration
  // ****************************************
  logic next_req;
  logic next_high;
  irq_ctrl_pkg::slot_t next_slot;

  always_comb begin
    next_req = 1'b0;
    next_high = 1'b0;
    next_slot = irq_ctrl_pkg::SLOT_PSM;
    if (!IN_SERVICE_HIGH_O && high_found) begin
      next_req = 1'b1;
      next_high = 1'b1;
      next_slot = high_slot;
    end else if (!IN_SERVICE_HIGH_O && !IN_SERVICE_LOW_O && low_found) begin
      next_req = 1'b1;
      next_high = 1'b0;
      next_slot = low_slot;
    end
    // The service state changes at this edge, so the request is withdrawn
    // for one cycle and judged again against the new state.
    if (IRQ_ACK_I || IRQ_RETURN_I) begin
      next_req = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_REQ_O <= 1'b0;
      IRQ_HIGH_O <= 1'b0;
      IRQ_SOURCE_O <= irq_ctrl_pkg::SLOT_PSM;
      IRQ_VECTOR_O <= irq_ctrl_pkg::VECTOR_NONE;
    end else begin
      IRQ_REQ_O <= next_req;
      IRQ_HIGH_O <= next_high;
      IRQ_SOURCE_O <= next_slot;
      IRQ_VECTOR_O <= irq_ctrl_pkg::vector_of(next_slot);
    end
  end

endmodule

// ===== verif/irq_ctrl_checker.sv
module irq_ctrl_checker (
  input logic CORE_CLK_I,
  input logic RST_I,
  input logic [7:0] SFR_ADDR_I,
  input logic SFR_RD_I,
  input logic IRQ_ACK_I,
  input logic IRQ_RETURN_I,
  input logic [7:0] SFR_RDATA_O,
  input logic SFR_RDATA_VALID_O,
  input logic IRQ_REQ_O,
  input logic [15:0] IRQ_VECTOR_O,
  input logic [3:0] IRQ_SOURCE_O,
  input logic IRQ_HIGH_O,
  input logic IN_SERVICE_HIGH_O,
  input logic IN_SERVICE_LOW_O
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] VEC_TAB [0:10] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
    16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  logic mapped;
  assign mapped = (SFR_ADDR_I == irq_ctrl_pkg::ADDR_ENABLE_MAIN) || (SFR_ADDR_I == irq_ctrl_pkg::ADDR_LEVEL_EXTRA)
    || (SFR_ADDR_I == irq_ctrl_pkg::ADDR_LEVEL_MAIN);

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  // ****************************************
  // Register port
  // ****************************************
  a_unmapped_read_quiet: assert property (SFR_RD_I && !mapped |=> !SFR_RDATA_VALID_O && SFR_RDATA_O == 8'h00)
    else $error("unmapped read answered");
  a_mapped_read_valid: assert property (SFR_RD_I && mapped |=> SFR_RDATA_VALID_O)
    else $error("mapped read not answered");
  a_idle_read_low: assert property (!SFR_RD_I |=> !SFR_RDATA_VALID_O)
    else $error("read valid without a read");

  // ****************************************
  // Interrupt link
  // ****************************************
  a_ack_sets_service: assert property (IRQ_ACK_I && IRQ_REQ_O |=>
    !IRQ_REQ_O && ($past(IRQ_HIGH_O) ? IN_SERVICE_HIGH_O : IN_SERVICE_LOW_O))
    else $error("ack did not enter service at the presented level");
  a_high_blocks_all: assert property (IN_SERVICE_HIGH_O |-> !IRQ_REQ_O)
    else $error("request presented during a high routine");
  a_low_only_high: assert property (IN_SERVICE_LOW_O && IRQ_REQ_O |-> IRQ_HIGH_O)
    else $error("low request presented during a low routine");
  a_return_drops_req: assert property (IRQ_RETURN_I |=> !IRQ_REQ_O)
    else $error("request not withdrawn after return");
  a_vector_matches_slot: assert property (IRQ_REQ_O |-> IRQ_VECTOR_O == VEC_TAB[IRQ_SOURCE_O])
    else $error("vector does not match source");
  a_watchdog_high_level: assert property (IRQ_REQ_O && IRQ_SOURCE_O == 4'h1 |-> IRQ_HIGH_O)
    else $error("watchdog presented at low level");

  c_ack_low: cover property (IRQ_ACK_I && IRQ_REQ_O && !IRQ_HIGH_O);
  c_preempt: cover property (IN_SERVICE_LOW_O && IRQ_REQ_O && IRQ_HIGH_O);
  c_nested: cover property (IN_SERVICE_LOW_O && IN_SERVICE_HIGH_O);
endmodule

bind two_level_interrupt_controller irq_ctrl_checker i_irq_ctrl_checker (.CORE_CLK_I, .RST_I, .SFR_ADDR_I,
  .SFR_RD_I, .IRQ_ACK_I, .IRQ_RETURN_I, .SFR_RDATA_O, .SFR_RDATA_VALID_O, .IRQ_REQ_O, .IRQ_VECTOR_O,
  .IRQ_SOURCE_O, .IRQ_HIGH_O, .IN_SERVICE_HIGH_O, .IN_SERVICE_LOW_O);

// ===== verif/core_stub.sv
module core_stub (
  input logic clk_i,
  input logic rst_i,
  input logic req_i,
  input logic [15:0] vector_i,
  input logic ack_en_i,
  input int lag_i,
  output logic ack_o,
  output logic [15:0] taken_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_cnt;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 0;
      taken_o <= 16'h0000;
    end else begin
      ack_o <= 1'b0;
      if (ack_en_i && req_i && !ack_o) begin
        if (wait_cnt >= lag_i) begin
          ack_o <= 1'b1;
          wait_cnt <= 0;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end else begin
        wait_cnt <= 0;
      end
      if (ack_o && req_i) begin
        taken_o <= vector_i;
      end
    end
  end
endmodule

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] VEC [0:10] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
    16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  localparam logic [3:0] FSLOT [0:13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9,
    4'h9, 4'hA};
  localparam logic [7:0] MEN [0:13] = '{8'h00, 8'h00, 8'h01, 8'h40, 8'h02, 8'h04, 8'h08, 8'h00, 8'h00,
    8'h10, 8'h10, 8'h20, 8'h20, 8'h00};
  localparam logic [7:0] XEN [0:13] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
  logic clk, rst, wr, rd, bit_wr, bit_val, ret, ack, ack_en, req, high, in_hi, in_lo, rvalid;
  logic [7:0] addr, wdata, bit_addr, rdata;
  logic [13:0] flags;
  logic [15:0] vector, taken;
  logic [3:0] source;
  int lag, error_cnt, total_checks, i;

  two_level_interrupt_controller i_two_level_interrupt_controller (.CORE_CLK_I(clk), .RST_I(rst),
    .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd), .BIT_ADDR_I(bit_addr),
    .BIT_VALUE_I(bit_val), .BIT_WR_I(bit_wr), .SUPPLY_MONITOR_IRQ_I(flags[0]), .WATCHDOG_IRQ_I(flags[1]),
    .EXT0_REQUEST_I(flags[2]), .ADC_DONE_IRQ_I(flags[3]), .TIMER0_OVERFLOW_I(flags[4]), .EXT1_REQUEST_I(flags[5]),
    .TIMER1_OVERFLOW_I(flags[6]), .I2C_IRQ_I(flags[7]), .SPI_IRQ_I(flags[8]), .UART_RX_FLAG_I(flags[9]),
    .UART_TX_FLAG_I(flags[10]), .TIMER2_OVERFLOW_I(flags[11]), .TIMER2_EXTERNAL_FLAG_I(flags[12]),
    .INTERVAL_COUNTER_IRQ_I(flags[13]), .IRQ_ACK_I(ack), .IRQ_RETURN_I(ret), .SFR_RDATA_O(rdata),
    .SFR_RDATA_VALID_O(rvalid), .IRQ_REQ_O(req), .IRQ_VECTOR_O(vector), .IRQ_SOURCE_O(source),
    .IRQ_HIGH_O(high), .IN_SERVICE_HIGH_O(in_hi), .IN_SERVICE_LOW_O(in_lo));
  core_stub i_core_stub (.clk_i(clk), .rst_i(rst), .req_i(req), .vector_i(vector), .ack_en_i(ack_en),
    .lag_i(lag), .ack_o(ack), .taken_o(taken));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic settle();
    repeat (2) cyc();
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc();
    wr = 1'b0;
    cyc();
  endtask
  task automatic sfr_bit(input logic [7:0] a, input logic v);
    bit_addr = a;
    bit_val = v;
    bit_wr = 1'b1;
    cyc();
    bit_wr = 1'b0;
    cyc();
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic vld);
    addr = a;
    rd = 1'b1;
    cyc();
    rd = 1'b0;
    chk(rvalid, vld);
    chk(rdata, exp);
    cyc();
  endtask
  task automatic do_return();
    ret = 1'b1;
    cyc();
    ret = 1'b0;
    settle();
  endtask
  task automatic expect_req(input logic [3:0] s, input logic h);
    chk(req, 1'b1);
    chk(source, s);
    chk(high, h);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst, wr, rd, bit_wr, bit_val, ret, ack_en} = 7'h40;
    {addr, wdata, bit_addr, flags, lag, error_cnt, total_checks} = '0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    sfr_rd(8'hA8, 8'h00, 1'b1);
    sfr_rd(8'hA9, 8'hA0, 1'b1);
    sfr_rd(8'hB8, 8'h00, 1'b1);
    sfr_rd(8'hA0, 8'h00, 1'b0);
    $display("test reset_values done");
    sfr_wr(8'hA9, 8'h77);
    sfr_rd(8'hA9, 8'hF7, 1'b1);
    sfr_wr(8'hB8, 8'hFF);
    sfr_rd(8'hB8, 8'h7F, 1'b1);
    sfr_bit(8'hAF, 1'b1);
    sfr_rd(8'hA8, 8'h80, 1'b1);
    sfr_wr(8'hB8, 8'h00);
    $display("test register_access done");
    for (i = 0; i < 14; i++) begin
      flags = 14'h0001 << i;
      sfr_wr(8'hA9, XEN[i]);
      sfr_wr(8'hA8, MEN[i]);
      settle();
      chk(req, 1'b0);
      sfr_wr(8'hA8, 8'h80 | MEN[i]);
      settle();
      expect_req(FSLOT[i], i == 1);
      chk(vector, VEC[FSLOT[i]]);
      if (i != 1) begin
        sfr_wr(8'hA8, 8'h80);
        sfr_wr(8'hA9, 8'h00);
        settle();
        chk(req, 1'b0);
      end
    end
    $display("test per_source done");
    flags = 14'h3FFD;
    sfr_wr(8'hA8, 8'hFF);
    sfr_wr(8'hA9, 8'h07);
    for (i = 0; i < 11; i++) begin
      if (i != 1) begin
        settle();
        expect_req(i[3:0], 1'b0);
        for (int f = 0; f < 14; f++) if (FSLOT[f] == i) flags[f] = 1'b0;
      end
    end
    settle();
    chk(req, 1'b0);
    $display("test polling_order done");
    flags = 14'h3FFD;
    sfr_bit(8'hBD, 1'b1);
    settle();
    expect_req(4'h9, 1'b1);
    sfr_wr(8'hA9, 8'h47);
    sfr_bit(8'hBD, 1'b0);
    settle();
    expect_req(4'hA, 1'b1);
    sfr_wr(8'hA9, 8'h27);
    settle();
    expect_req(4'h0, 1'b1);
    sfr_wr(8'hA9, 8'h00);
    flags = '0;
    $display("test levels done");
    flags[4] = 1'b1;
    sfr_wr(8'hA8, 8'h82);
    ack_en = 1'b1;
    for (i = 0; i < 20 && in_lo !== 1'b1; i++) cyc();
    chk(taken, 16'h000B);
    flags[5] = 1'b1;
    sfr_bit(8'hAA, 1'b1);
    settle();
    chk(req, 1'b0);
    lag = 3;
    flags[2] = 1'b1;
    sfr_bit(8'hB8, 1'b1);
    sfr_bit(8'hA8, 1'b1);
    for (i = 0; i < 20 && in_hi !== 1'b1; i++) cyc();
    chk({in_hi, in_lo}, 2'b11);
    chk(taken, 16'h0003);
    flags[2] = 1'b0;
    flags[4] = 1'b0;
    do_return();
    chk({in_hi, in_lo, req}, 3'b010);
    do_return();
    for (i = 0; i < 20 && taken !== 16'h0013; i++) cyc();
    chk(taken, 16'h0013);
    ack_en = 1'b0;
    flags = '0;
    do_return();
    chk({in_hi, in_lo}, 2'b00);
    $display("test preemption done");
    rst = 1'b1;
    cyc();
    rst = 1'b0;
    chk({req, in_hi, in_lo}, 3'b000);
    sfr_rd(8'hA8, 8'h00, 1'b1);
    sfr_rd(8'hA9, 8'hA0, 1'b1);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule
